// file: uep_mux_block_former.sv
// branch multiplexer and single-carrier block former with apb registers
//
// Summary of operation
// - msb-only mode merges branches with the plain four-branch index mapping.
// - bit mux mode picks branch and position from k modulo 48.
// - residues 0..27 feed branches 0..3 in runs of 7, rest 4..7 in fives.
// - symbol modes interleave msb and lsb branches with factor 2 or 4.
// - interleaved symbols are cut into blocks of exactly 252.
// - four pilots -1,+1,-1,+1 follow every data block.
// - cyclic prefix copies the last prefix-length symbols of the block.
// - prefix length is only 0, 32, 64 or 96.
// - prefix length follows the request field of the last received frame.
// - first frame or multi-destination frames use prefix length 96.
// - midamble symbols repeat the channel-estimation sequence unchanged.
// - bonding two to four channels leaves block forming unchanged.
// - bonded symbol rate is 3.456, 5.184 or 6.912 Gsps.
// - msb-only mode sends msb branches only and drops lsb branch data.
// - four-branch mapping takes branch floor(k/K) mod 4 in sequence.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module uep_mux_block_former
  import uep_pkg::*;
#(
  parameter int MID_LEN = MID_LEN_DEF
) (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // encoder branches
  input  wire logic [NUM_BR-1:0]           br_valid,
  input  wire logic [NUM_BR-1:0][SYM_W-1:0] br_data,
  output logic      [NUM_BR-1:0]           br_ready,
  // multiplexed stream towards mapper
  output logic                             mux_valid,
  output logic      [SYM_W-1:0]            mux_data,
  input  wire logic                        mux_ready,
  // interleaved symbols back in
  input  wire logic                        ilv_valid,
  input  wire logic [SYM_W-1:0]            ilv_data,
  output logic                             ilv_ready,
  // channel-estimation sequence source
  input  wire logic                        ce_valid,
  input  wire logic [SYM_W-1:0]            ce_data,
  output logic                             ce_ready,
  // block stream towards modulator
  output logic                             blk_valid,
  output logic      [SYM_W-1:0]            blk_data,
  input  wire logic                        blk_ready,
  // symbol clock rate select
  output logic      [1:0]                  rate_sel
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] mux_period(input uep_mode_t m);
    case (m)
      uep_msb_only_mode:       mux_period = PERIOD_MSB;
      uep_bit_mux_mode:        mux_period = PERIOD_BIT;
      uep_symbol_mux_low_mode: mux_period = PERIOD_LOW;
      default:                 mux_period = PERIOD_HIGH;
    endcase
  endfunction : mux_period

  function automatic logic [2:0] branch_of(input uep_mode_t m, input logic [5:0] k);
    logic [5:0] r;
    r = 6'h00;
    case (m)
      uep_msb_only_mode: begin
        branch_of = {1'b0, k[1:0]};
      end
      uep_bit_mux_mode: begin
        if (k < BIT_LSB_BASE) begin
          r = k / BIT_RUN_MSB;
          branch_of = r[2:0];
        end else begin
          r = (k - BIT_LSB_BASE) / BIT_RUN_LSB;
          branch_of = 3'h4 + r[2:0];
        end
      end
      uep_symbol_mux_low_mode: begin
        branch_of = {k[0], k[2:1]};
      end
      default: begin
        branch_of = {k[1], k[3:2]};
      end
    endcase
  endfunction : branch_of

  function automatic logic [6:0] prefix_of(input logic first, input logic multi,
                                           input logic [1:0] code);
    logic [6:0] c;
    c = {5'h00, code};
    if (first || multi) begin
      prefix_of = CP_MAX;
    end else begin
      prefix_of = 7'(c * CP_STEP);
    end
  endfunction : prefix_of

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0]  ctrl;
  logic [1:0]  req_code;
  logic [15:0] blk_count;
  uep_state_t  state;
  logic [6:0]  prefix_length;
  logic        mid_start;

  uep_mode_t   mode;
  wire logic [1:0] bond     = ctrl[CTRL_BOND_LSB +: 2];
  wire logic       run      = ctrl[CTRL_EN_BIT];
  wire logic       mid_req  = ctrl[CTRL_MID_BIT];
  wire logic       acc      = psel && penable && !pready;
  wire logic       wr_acc   = psel && penable && pready && pwrite;
  wire logic       hit_ctrl = (paddr == OFS_CTRL);
  wire logic       hit_pfx  = (paddr == OFS_PREFIX);
  wire logic       hit_stat = (paddr == OFS_STATUS);
  wire logic       hit_rate = (paddr == OFS_RATE);
  wire logic       mapped   = hit_ctrl || hit_pfx || hit_stat || hit_rate;
  wire logic       ctrl_wr  = wr_acc && hit_ctrl;
  wire logic [15:0] rate_now = (bond == 2'h1) ? RATE_2CH :
                               (bond == 2'h2) ? RATE_3CH :
                               (bond == 2'h3) ? RATE_4CH : RATE_1CH;
  wire logic [31:0] rd_mux =
    hit_ctrl ? {23'h000000, ctrl} :
    hit_pfx  ? {30'h00000000, req_code} :
    hit_stat ? {blk_count, 3'h0, state, 1'b0, prefix_length} :
    hit_rate ? {16'h0000, rate_now} : 32'h00000000;

  assign mode = uep_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      prdata  <= (acc && !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= acc && !mapped;
    end
  end

  // a midamble start in the write cycle keeps the newly written request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl     <= CTRL_RESET;
      req_code <= PREFIX_RESET;
      rate_sel <= 2'h0;
    end else begin
      if (ctrl_wr) begin
        ctrl <= pwdata[8:0];
      end else if (mid_start) begin
        ctrl[CTRL_MID_BIT] <= 1'b0;
      end
      if (wr_acc && hit_pfx) begin
        req_code <= pwdata[1:0];
      end
      rate_sel <= bond;
    end
  end

  // ----------------------------------------------------------------
  // branch multiplexer
  // ----------------------------------------------------------------
  logic [5:0]       kc;
  logic [1:0]       mcnt;
  logic [SYM_W-1:0] m_d1;

  wire logic [2:0]  sel      = branch_of(mode, kc);
  wire logic        m_push   = run && br_valid[sel] && br_ready[sel];
  wire logic        m_pop    = mux_valid && mux_ready;
  wire logic [5:0]  kc_inc   = kc + 6'h01;
  wire logic [5:0]  next_kc  = ctrl_wr ? 6'h00 :
                               !m_push ? kc :
                               (kc_inc == mux_period(mode)) ? 6'h00 : kc_inc;
  wire logic [1:0]  next_mcnt = 2'(mcnt + {1'b0, m_push} - {1'b0, m_pop});
  wire logic [2:0]  next_sel  = branch_of(mode, next_kc);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      kc        <= 6'h00;
      mcnt      <= 2'h0;
      mux_valid <= 1'b0;
      br_ready  <= '0;
    end else begin
      kc        <= next_kc;
      mcnt      <= next_mcnt;
      mux_valid <= (next_mcnt != 2'h0);
      for (int m = 0; m < NUM_BR; m++) begin
        br_ready[m] <= (run && next_mcnt != 2'h2 && next_sel == 3'(m)) ||
                       (run && mode == uep_msb_only_mode && m >= 4);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (m_push && m_pop) begin
      if (mcnt == 2'h1) mux_data <= br_data[sel];
      else begin
        mux_data <= m_d1;
        m_d1     <= br_data[sel];
      end
    end else if (m_pop) begin
      mux_data <= m_d1;
    end else if (m_push) begin
      if (mcnt == 2'h0) mux_data <= br_data[sel];
      else m_d1 <= br_data[sel];
    end
  end

  // ----------------------------------------------------------------
  // block store: one bank fills while the other is sent
  // ----------------------------------------------------------------
  logic       wr_bank;
  logic [7:0] wr_cnt;
  logic [1:0] bank_full;
  logic       rd_bank;
  logic [7:0] idx;
  logic       bank_done;

  wire logic       w_push     = ilv_valid && ilv_ready;
  wire logic       w_last     = (wr_cnt == 8'(DATA_LEN - 1));
  wire logic       next_wbank = (w_push && w_last) ? !wr_bank : wr_bank;
  wire logic [1:0] set_full   = (w_push && w_last) ? (2'h1 << wr_bank) : 2'h0;
  wire logic [1:0] clr_full   = bank_done ? (2'h1 << rd_bank) : 2'h0;
  wire logic [1:0] next_full  = (bank_full & ~clr_full) | set_full;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_bank   <= 1'b0;
      wr_cnt    <= 8'h00;
      bank_full <= 2'h0;
      ilv_ready <= 1'b0;
    end else begin
      wr_bank   <= next_wbank;
      bank_full <= next_full;
      if (w_push) begin
        wr_cnt <= w_last ? 8'h00 : wr_cnt + 8'h01;
      end
      ilv_ready <= !next_full[next_wbank];
    end
  end

  // ----------------------------------------------------------------
  // block reader: prefix, data, pilots, optional midamble
  // ----------------------------------------------------------------
  logic             st_valid;
  logic             st_mem;
  logic [SYM_W-1:0] st_const;
  logic [SYM_W-1:0] ram_q;
  logic [1:0]       ocnt;
  logic [SYM_W-1:0] o_d1;
  logic [7:0]       mid_cnt;

  wire logic       o_pop    = blk_valid && blk_ready;
  wire logic       space    = (2'(ocnt - {1'b0, o_pop}) + {1'b0, st_valid}) < 2'h2;
  wire logic       other_rdy = bank_full[rd_bank] || bank_full[!rd_bank];
  wire logic [6:0] cp_now   = prefix_of(ctrl[CTRL_FIRST_BIT], ctrl[CTRL_MULTI_BIT],
                                        req_code);
  wire logic [7:0] cp_start = 8'(BLOCK_LEN) - {1'b0, cp_now};
  wire logic [7:0] p_first  = 8'(BLOCK_LEN) - {1'b0, prefix_length};
  wire logic       ce_take  = ce_valid && ce_ready;
  wire logic       is_pilot = (idx >= 8'(DATA_LEN));
  wire logic [SYM_W-1:0] pilot_sym = idx[0] ? PILOT_POS : PILOT_NEG;
  wire logic       issue    = space && (state == ST_PREFIX || state == ST_DATA ||
                                        state == ST_PILOT);
  wire logic       rd_en    = issue && !(state == ST_PILOT || is_pilot);
  wire logic [RAM_AW-1:0] rd_addr = {rd_bank, idx};
  wire logic [SYM_W-1:0]  st_out  = st_mem ? ram_q : st_const;
  wire logic [1:0] next_ocnt = 2'(ocnt + {1'b0, st_valid} - {1'b0, o_pop});
  wire logic       blk_end  = issue && state == ST_PILOT &&
                              idx == 8'(BLOCK_LEN - 1);
  wire logic       mid_end  = ce_take && mid_cnt == 8'(MID_LEN - 1);
  wire logic       start_ok = run && bank_full[rd_bank];

  assign bank_done = blk_end;
  assign mid_start = (blk_end || state == ST_IDLE) && mid_req && run;

  uep_sym_ram #(
    .W  (SYM_W),
    .AW (RAM_AW)
  ) u_ram (
    .clk_sys (clk_sys),
    .wr_en   (w_push),
    .wr_addr ({wr_bank, wr_cnt}),
    .wr_data (ilv_data),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (ram_q)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state         <= ST_IDLE;
      rd_bank       <= 1'b0;
      idx           <= 8'h00;
      prefix_length <= CP_MAX;
      blk_count     <= 16'h0000;
      mid_cnt       <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (mid_start) begin
            state   <= ST_MID;
            mid_cnt <= 8'h00;
          end else if (start_ok) begin
            prefix_length <= cp_now;
            idx           <= cp_start;
            state         <= (cp_now == 7'h00) ? ST_DATA : ST_PREFIX;
          end
        end
        ST_PREFIX: begin
          if (issue) begin
            idx <= idx + 8'h01;
            if (idx == 8'(BLOCK_LEN - 1)) begin
              idx   <= 8'h00;
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (issue) begin
            idx <= idx + 8'h01;
            if (idx == 8'(DATA_LEN - 1)) state <= ST_PILOT;
          end
        end
        ST_PILOT: begin
          if (issue) begin
            idx <= idx + 8'h01;
            if (blk_end) begin
              rd_bank   <= !rd_bank;
              blk_count <= blk_count + 16'h0001;
              if (mid_start) begin
                state   <= ST_MID;
                mid_cnt <= 8'h00;
              end else if (run && bank_full[!rd_bank]) begin
                prefix_length <= cp_now;
                idx           <= cp_start;
                state         <= (cp_now == 7'h00) ? ST_DATA : ST_PREFIX;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_MID: begin
          if (ce_take) begin
            mid_cnt <= mid_cnt + 8'h01;
            if (mid_end) state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // stage between store read and output buffer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_valid <= 1'b0;
      st_mem   <= 1'b0;
      st_const <= '0;
      ce_ready <= 1'b0;
    end else begin
      st_valid <= issue || ce_take;
      st_mem   <= rd_en;
      st_const <= ce_take ? ce_data : pilot_sym;
      ce_ready <= state == ST_MID && !mid_end && next_ocnt == 2'h0 &&
                  !(issue || ce_take) && !ce_take;
    end
  end

  // two-entry output buffer; a modulator stall loses no symbol
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ocnt      <= 2'h0;
      blk_valid <= 1'b0;
    end else begin
      ocnt      <= next_ocnt;
      blk_valid <= (next_ocnt != 2'h0);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (st_valid && o_pop) begin
      if (ocnt == 2'h1) blk_data <= st_out;
      else begin
        blk_data <= o_d1;
        o_d1     <= st_out;
      end
    end else if (o_pop) begin
      blk_data <= o_d1;
    end else if (st_valid) begin
      if (ocnt == 2'h0) blk_data <= st_out;
      else o_d1 <= st_out;
    end
  end

  // bonding only changes rate_sel and the rate register readback; the framing above ignores it


endmodule : uep_mux_block_former

// file: uep_pkg.sv
// shared constants and types for the unequal-protection mux and block former
package uep_pkg;

  // ----------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------
  localparam int SYM_W       = 16;
  localparam int NUM_BR      = 8;
  localparam int DATA_LEN    = 252;
  localparam int PILOT_LEN   = 4;
  localparam int BLOCK_LEN   = 256;
  localparam int RAM_AW      = 9;
  localparam int MID_LEN_DEF = 128;

  // pilot values, i in upper byte, q in lower byte
  localparam logic [SYM_W-1:0] PILOT_NEG = 16'h8100;
  localparam logic [SYM_W-1:0] PILOT_POS = 16'h7F00;

  // ----------------------------------------------------------------
  // multiplexer patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] PERIOD_MSB  = 6'h04;
  localparam logic [5:0] PERIOD_BIT  = 6'h30;
  localparam logic [5:0] PERIOD_LOW  = 6'h08;
  localparam logic [5:0] PERIOD_HIGH = 6'h10;
  localparam logic [5:0] BIT_RUN_MSB = 6'h07;
  localparam logic [5:0] BIT_RUN_LSB = 6'h05;
  localparam logic [5:0] BIT_LSB_BASE = 6'h1C;

  // ----------------------------------------------------------------
  // cyclic prefix and symbol rate
  // ----------------------------------------------------------------
  localparam logic [6:0] CP_STEP  = 7'h20;
  localparam logic [6:0] CP_MAX   = 7'h60;
  localparam logic [15:0] RATE_1CH = 16'h06C0;
  localparam logic [15:0] RATE_2CH = 16'h0D80;
  localparam logic [15:0] RATE_3CH = 16'h1440;
  localparam logic [15:0] RATE_4CH = 16'h1B00;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PREFIX = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RATE   = 8'h0C;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_BOND_LSB  = 2;
  localparam int CTRL_FIRST_BIT = 4;
  localparam int CTRL_MULTI_BIT = 5;
  localparam int CTRL_MID_BIT   = 6;
  localparam int CTRL_EN_BIT    = 8;
  localparam int STAT_ST_LSB    = 8;
  localparam int STAT_CNT_LSB   = 16;
  localparam logic [8:0] CTRL_RESET   = 9'h010;
  localparam logic [1:0] PREFIX_RESET = 2'h3;

  typedef enum logic [1:0] {
    uep_msb_only_mode        = 2'h0,
    uep_bit_mux_mode         = 2'h1,
    uep_symbol_mux_low_mode  = 2'h2,
    uep_symbol_mux_high_mode = 2'h3
  } uep_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_PREFIX = 5'h02,
    ST_DATA   = 5'h04,
    ST_PILOT  = 5'h08,
    ST_MID    = 5'h10
  } uep_state_t;

endpackage : uep_pkg

// file: uep_sym_ram.sv
// two-bank symbol store with registered read data
`timescale 1ns/1ns
module uep_sym_ram #(
  parameter int W  = 16,
  parameter int AW = 9
) (
  // clock
  input  wire logic          clk_sys,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read side
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : uep_sym_ram

// file: uep_mux_block_former_props.sv
// port assertions for the unequal-protection mux and block former
`timescale 1ns/1ns
module uep_mux_block_former_props
  import uep_pkg::*;
(
  // clock, reset and apb
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  // streams
  input wire logic [NUM_BR-1:0] br_valid,
  input wire logic [NUM_BR-1:0] br_ready,
  input wire logic              mux_valid,
  input wire logic [SYM_W-1:0]  mux_data,
  input wire logic              mux_ready,
  input wire logic              blk_valid,
  input wire logic [SYM_W-1:0]  blk_data,
  input wire logic              blk_ready
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic last_neg;
  wire  blk_fire = blk_valid && blk_ready;

  // set while the last symbol taken downstream was a negative pilot
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_neg <= 1'b0;
    end else if (blk_fire) begin
      last_neg <= (blk_data == PILOT_NEG);
    end
  end

  sequence apb_take_s;
    psel && penable && !pready;
  endsequence
  sequence blk_stall_s;
    blk_valid && !blk_ready;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  apb_answer_a:
    assert property (apb_take_s |=> pready) else $error("apb access unanswered");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready held too long");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  mux_hold_a:
    assert property (mux_valid && !mux_ready |=> mux_valid && $stable(mux_data))
    else $error("mux symbol lost");
  blk_hold_a:
    assert property (blk_stall_s |=> blk_valid && $stable(blk_data))
    else $error("block symbol lost");
  pilot_pair_a:
    assert property (blk_fire && last_neg |-> blk_data == PILOT_POS)
    else $error("pilot order wrong");
  mux_follow_a:
    assert property (|(br_valid[3:0] & br_ready[3:0]) |=> mux_valid)
    else $error("taken symbol not offered");
  reset_quiet_a:
    assert property ($fell(rst) |-> !pready && !mux_valid && !blk_valid && br_ready == '0)
    else $error("outputs active after reset");
endmodule : uep_mux_block_former_props

// file: uep_far_model.sv
// far-side model: eight encoder branches and the modulator ready
`timescale 1ns/1ns
module uep_far_model
  import uep_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // encoder branches
  input  wire logic [NUM_BR-1:0]            br_ready,
  output logic      [NUM_BR-1:0]            br_valid,
  output logic      [NUM_BR-1:0][SYM_W-1:0] br_data,
  // modulator, slow takes one symbol in four
  input  wire logic                         slow,
  output logic                              blk_ready
);
  logic [NUM_BR-1:0][11:0] sent;
  logic [1:0]              tick;

  // each branch offers branch number over its running index
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sent <= '0;
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
      for (int m = 0; m < NUM_BR; m++) begin
        if (br_valid[m] && br_ready[m]) begin
          sent[m] <= sent[m] + 12'h001;
        end
      end
    end
  end
  always_comb begin
    for (int m = 0; m < NUM_BR; m++) begin
      br_data[m] = {4'(m), sent[m]};
    end
  end
  assign br_valid  = {NUM_BR{!rst}};
  assign blk_ready = !slow || (tick == 2'h3);
endmodule : uep_far_model

// file: uep_mux_block_former_test.sv
// self-checking bench for the unequal-protection mux and block former
`timescale 1ns/1ns
`define CHECK(w, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", w, e, g); end end
module uep_mux_block_former_test
  import uep_pkg::*;
;
  logic              clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, perr;
  logic              pwrite = 1'b0, mux_ready = 1'b0, slow = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0, prdata, rdat;
  logic              pready, pslverr, mux_valid, ilv_valid, ilv_ready;
  logic              ce_valid, ce_ready, blk_valid, blk_ready;
  logic [NUM_BR-1:0] br_valid, br_ready;
  logic [SYM_W-1:0]  mux_data, ilv_data, ce_data, blk_data, mux_q[$], blk_q[$];
  logic [1:0]        rate_sel;
  int                num_errors = 0, comparisons = 0, cycles = 0, ilv_cnt = 0, ilv_lim = 0;
  int                ce_cnt = 0;
  logic [NUM_BR-1:0][SYM_W-1:0] br_data;

  always #5 clk_sys = ~clk_sys;

  uep_mux_block_former #(.MID_LEN(4)) u_uep_mux_block_former (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .br_valid, .br_data, .br_ready, .mux_valid, .mux_data, .mux_ready, .ilv_valid, .ilv_data,
    .ilv_ready, .ce_valid, .ce_data, .ce_ready, .blk_valid, .blk_data, .blk_ready, .rate_sel);
  uep_far_model u_uep_far_model (.clk_sys, .rst, .br_ready, .br_valid, .br_data, .slow,
    .blk_ready);

  // ----------------------------------------------------------------
  // sources, sinks and watchdog
  // ----------------------------------------------------------------
  assign ilv_valid = !rst && (ilv_cnt < ilv_lim);
  assign ilv_data  = 16'h1000 + 16'(ilv_cnt);
  assign ce_valid  = !rst;
  assign ce_data   = 16'h2000 + 16'(ce_cnt);
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    mux_ready <= !mux_ready;
    if (rst) begin
      ilv_cnt <= 0;
      ce_cnt <= 0;
    end else begin
      if (ilv_valid && ilv_ready) ilv_cnt <= ilv_cnt + 1;
      if (ce_valid && ce_ready) ce_cnt <= ce_cnt + 1;
      if (mux_valid && mux_ready) mux_q.push_back(mux_data);
      if (blk_valid && blk_ready) blk_q.push_back(blk_data);
    end
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    ilv_lim <= 0;
    @(posedge clk_sys);
    mux_q.delete();
    blk_q.delete();
  endtask : do_reset

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    do_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHECK("ctrl reset", 32'(CTRL_RESET), rdat)
    apb(1'b0, 8'h10, 32'h0);
    `CHECK("unmapped", 33'h1_0000_0000, {perr, rdat})
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, OFS_CTRL, 32'(b << 2));
      apb(1'b0, OFS_RATE, 32'h0);
      `CHECK("rate", 32'(RATE_1CH) * (b + 1), rdat)
      `CHECK("rate_sel", 2'(b), rate_sel)
    end
  endtask : t_regs

  task automatic t_mux(input int mode);
    int kk;
    int r;
    int m;
    int i;
    logic [15:0] e;
    do_reset();
    apb(1'b1, OFS_CTRL, 32'h100 | 32'(mode));
    repeat (3000) if (mux_q.size() < 48) @(posedge clk_sys);
    kk = (mode < 2) ? 1 : 2 * mode - 2;
    for (int k = 0; k < 48; k++) begin
      r = k % 48;
      m = (k / kk) % 4 + ((mode < 2) ? 0 : 4 * ((2 * k / kk) % 2));
      i = (mode < 2) ? k / 4 : k % (kk / 2) + (kk / 2) * (k / (4 * kk));
      if (mode == 1) begin
        m = (r < 28) ? r / 7 : 4 + (r - 28) / 5;
        i = (r < 28) ? 7 * (k / 48) + r % 7 : 5 * (k / 48) + (r - 28) % 5;
      end
      e = {4'(m), 12'(i)};
      if (mode < 2) begin
        `CHECK("mux bit", e, mux_q[k])
      end else begin
        `CHECK("mux symbol", e, mux_q[k])
      end
    end
  endtask : t_mux

  task automatic t_block(input logic [31:0] ctrl, input int code, n, nblk, input logic stall);
    int len;
    int p;
    logic [15:0] e;
    do_reset();
    slow <= stall;
    len = n + BLOCK_LEN;
    apb(1'b1, OFS_PREFIX, 32'(code));
    apb(1'b1, OFS_CTRL, ctrl);
    ilv_lim <= DATA_LEN * nblk;
    repeat (4000 * nblk) if (blk_q.size() < len * nblk) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
    `CHECK("block count", len * nblk, blk_q.size())
    for (int j = 0; j < len * nblk; j++) begin
      p = (j % len < n) ? BLOCK_LEN - n + j % len : j % len - n;
      e = (p % 2) ? PILOT_POS : PILOT_NEG;
      if (p < DATA_LEN) e = 16'h1000 + 16'(DATA_LEN * (j / len) + p);
      `CHECK("block symbol", e, blk_q[j])
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHECK("prefix in use", 7'(n), rdat[6:0])
    `CHECK("blocks done", 16'(nblk), rdat[31:16])
  endtask : t_block

  task automatic t_mid;
    do_reset();
    apb(1'b1, OFS_CTRL, 32'h140);
    repeat (300) @(posedge clk_sys);
    `CHECK("midamble count", 4, blk_q.size())
    for (int j = 0; j < 4; j++) begin
      `CHECK("midamble symbol", 16'h2000 + 16'(j), blk_q[j])
    end
  endtask : t_mid

  initial begin
    t_regs();
    for (int md = 0; md < 4; md++) t_mux(md);
    t_block(32'h110, 2, 96, 1, 1'b0);
    t_block(32'h100, 1, 32, 2, 1'b1);
    t_block(32'h120, 0, 96, 1, 1'b0);
    t_block(32'h100, 0, 0, 1, 1'b1);
    t_block(32'h100, 3, 96, 1, 1'b0);
    t_block(32'h100, 2, 64, 1, 1'b0);
    t_mid();
    end_of_test();
  end
endmodule : uep_mux_block_former_test

bind uep_mux_block_former uep_mux_block_former_props u_uep_mux_block_former_props (
  .clk_sys, .rst, .psel, .penable, .pready, .pslverr, .br_valid, .br_ready, .mux_valid,
  .mux_data, .mux_ready, .blk_valid, .blk_data, .blk_ready);
